// [common/tpg_pkg.sv]
package tpg_pkg;
  localparam int TPG_AW = 3;
  localparam int TPG_DW = 8;
  localparam int TPG_PC_W = 3;
  // register offsets
  localparam logic [2:0] TPG_OFF_PA_DATA = 3'h0;
  localparam logic [2:0] TPG_OFF_PA_DIR = 3'h1;
  localparam logic [2:0] TPG_OFF_PB_DATA = 3'h2;
  localparam logic [2:0] TPG_OFF_PB_DIR = 3'h3;
  localparam logic [2:0] TPG_OFF_PC_DATA = 3'h4;
  localparam logic [2:0] TPG_OFF_PC_DIR = 3'h5;
  localparam logic [2:0] TPG_OFF_CTRL = 3'h6;
  localparam logic [2:0] TPG_OFF_RSVD7 = 3'h7;
  // reset values
  localparam logic [7:0] TPG_RST_DATA = 8'h00;
  localparam logic [7:0] TPG_RST_DIR = 8'h00;
  localparam logic [7:0] TPG_RST_CTRL = 8'h00;
  localparam logic [7:0] TPG_RD_RSVD = 8'h00;
  // control register fields (offset 6)
  localparam int TPG_CTRL_USB_SEL = 0;
  localparam int TPG_CTRL_SERIAL_EN = 1;
  localparam int TPG_CTRL_SMALL_PKG = 2;
  localparam int TPG_CTRL_IRQ_EN_LO = 4;
  localparam int TPG_CTRL_IRQ_EN_W = 4;
  // pin positions
  localparam int TPG_PA_OD_LO = 1;
  localparam int TPG_PA_OD_HI = 2;
  localparam int TPG_PB_USB_PIN = 1;
  localparam int TPG_PB_IRQ_LO = 4;
  localparam int TPG_PC_RX_PIN = 0;
  localparam int TPG_PC_TX_PIN = 1;
  localparam int TPG_PC_USB_PIN = 2;
  localparam logic [7:0] TPG_PA_OD_MASK = 8'h06;
endpackage

// [rtl/tpg_bank.sv]
`timescale 1ns/1ps
// Behaviour
// - direction bit 0 makes pin input, 1 makes it output; all writable.
// - data writes always update the output latch, even for inputs.
// - data read gives latch for push-pull outputs, pin level for inputs.
// - open-drain output pins read back the actual pin level.
// - port C has three pins; bits 7 to 3 not accessible.
// - port A pins 1,2 open drain, no pull-up, never drive high.
// - port B pins 4..7 are irq inputs five..eight, enabled by four..seven.
// - usb select drives usb transmit indicator on port C pin 2 or B pin 1.
// - peripheral output claim overrides data and direction for that pin.
// - enabled irq pins sharing one vector are ORed together.
module tpg_bank (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register port
  input wire logic [tpg_pkg::TPG_AW-1:0] reg_addr,
  input wire logic [tpg_pkg::TPG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tpg_pkg::TPG_DW-1:0] reg_rdata,
  // port A pins
  input wire logic [tpg_pkg::TPG_DW-1:0] pa_i,
  output logic [tpg_pkg::TPG_DW-1:0] pa_o,
  output logic [tpg_pkg::TPG_DW-1:0] pa_oe,
  // port B pins
  input wire logic [tpg_pkg::TPG_DW-1:0] pb_i,
  output logic [tpg_pkg::TPG_DW-1:0] pb_o,
  output logic [tpg_pkg::TPG_DW-1:0] pb_oe,
  // port C pins
  input wire logic [tpg_pkg::TPG_PC_W-1:0] pc_i,
  output logic [tpg_pkg::TPG_PC_W-1:0] pc_o,
  output logic [tpg_pkg::TPG_PC_W-1:0] pc_oe,
  // peripheral side
  input wire logic usb_tx_active,
  input wire logic serial_tx,
  output logic serial_receive_in,
  output logic ext_irq_req
);
  import tpg_pkg::*;

  typedef struct packed {
    logic [TPG_DW-1:0] rdata;
    logic [TPG_DW-1:0] ctrl;
    logic rx;
    logic irq;
  } tpg_bank_st_t;

  tpg_bank_st_t st_r, st_nxt;

  logic wa_d, wa_r, wb_d, wb_r, wc_d, wc_r;
  logic [TPG_DW-1:0] a_data, a_dir, a_rd, b_data, b_dir, b_rd;
  logic [TPG_PC_W-1:0] c_data, c_dir, c_rd;
  logic [TPG_DW-1:0] b_alt_en, b_alt_val;
  logic [TPG_PC_W-1:0] c_alt_en, c_alt_val;
  logic usb_sel, ser_en, small_pkg;
  logic [TPG_CTRL_IRQ_EN_W-1:0] irq_en;

  ////////////////////////////////////////////////////////////////////////
  // write decode
  always_comb begin
    wa_d = reg_wr && reg_addr == TPG_OFF_PA_DATA;
    wa_r = reg_wr && reg_addr == TPG_OFF_PA_DIR;
    wb_d = reg_wr && reg_addr == TPG_OFF_PB_DATA;
    wb_r = reg_wr && reg_addr == TPG_OFF_PB_DIR;
    wc_d = reg_wr && reg_addr == TPG_OFF_PC_DATA;
    wc_r = reg_wr && reg_addr == TPG_OFF_PC_DIR;
  end

  assign usb_sel = st_r.ctrl[TPG_CTRL_USB_SEL];
  assign ser_en = st_r.ctrl[TPG_CTRL_SERIAL_EN];
  assign small_pkg = st_r.ctrl[TPG_CTRL_SMALL_PKG];
  assign irq_en = st_r.ctrl[TPG_CTRL_IRQ_EN_LO +: TPG_CTRL_IRQ_EN_W];

  ////////////////////////////////////////////////////////////////////////
  // peripheral overrides
  always_comb begin
    b_alt_en = '0;
    b_alt_val = '0;
    c_alt_en = '0;
    c_alt_val = '0;
    b_alt_en[TPG_PB_USB_PIN] = usb_sel && small_pkg;
    b_alt_val[TPG_PB_USB_PIN] = usb_tx_active;
    c_alt_en[TPG_PC_USB_PIN] = usb_sel && !small_pkg;
    c_alt_val[TPG_PC_USB_PIN] = usb_tx_active;
    c_alt_en[TPG_PC_TX_PIN] = ser_en;
    c_alt_val[TPG_PC_TX_PIN] = serial_tx;
  end

  ////////////////////////////////////////////////////////////////////////
  // ports
  tpg_port #(.W(TPG_DW), .OD_MASK(TPG_PA_OD_MASK)) u_pa (
    .sys_clk(sys_clk), .resetn(resetn),
    .wr_data(wa_d), .wr_dir(wa_r), .wdata(reg_wdata),
    .data_q(a_data), .dir_q(a_dir), .rd_val(a_rd),
    .alt_en('0), .alt_val('0),
    .pin_i(pa_i), .pin_o(pa_o), .pin_oe(pa_oe)
  );

  tpg_port #(.W(TPG_DW), .OD_MASK('0)) u_pb (
    .sys_clk(sys_clk), .resetn(resetn),
    .wr_data(wb_d), .wr_dir(wb_r), .wdata(reg_wdata),
    .data_q(b_data), .dir_q(b_dir), .rd_val(b_rd),
    .alt_en(b_alt_en), .alt_val(b_alt_val),
    .pin_i(pb_i), .pin_o(pb_o), .pin_oe(pb_oe)
  );

  // only the three low bits are stored for port C
  tpg_port #(.W(TPG_PC_W), .OD_MASK('0)) u_pc (
    .sys_clk(sys_clk), .resetn(resetn),
    .wr_data(wc_d), .wr_dir(wc_r), .wdata(reg_wdata[TPG_PC_W-1:0]),
    .data_q(c_data), .dir_q(c_dir), .rd_val(c_rd),
    .alt_en(c_alt_en), .alt_val(c_alt_val),
    .pin_i(pc_i), .pin_o(pc_o), .pin_oe(pc_oe)
  );

  ////////////////////////////////////////////////////////////////////////
  // read mux, control register, irq and serial input
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = '0;
    if (reg_wr && reg_addr == TPG_OFF_CTRL) begin
      st_nxt.ctrl = reg_wdata;
      st_nxt.ctrl[TPG_CTRL_IRQ_EN_LO-1] = 1'b0;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        TPG_OFF_PA_DATA: st_nxt.rdata = a_rd;
        TPG_OFF_PA_DIR: st_nxt.rdata = a_dir;
        TPG_OFF_PB_DATA: st_nxt.rdata = b_rd;
        TPG_OFF_PB_DIR: st_nxt.rdata = b_dir;
        TPG_OFF_PC_DATA: st_nxt.rdata = {{(TPG_DW-TPG_PC_W){1'b0}}, c_rd};
        TPG_OFF_PC_DIR: st_nxt.rdata = {{(TPG_DW-TPG_PC_W){1'b0}}, c_dir};
        TPG_OFF_CTRL: st_nxt.rdata = st_r.ctrl;
        TPG_OFF_RSVD7: st_nxt.rdata = TPG_RD_RSVD;
      endcase
    end
    // irq only from pins in input mode with enable set
    st_nxt.irq = |(pb_i[TPG_PB_IRQ_LO +: TPG_CTRL_IRQ_EN_W] & irq_en
      & ~b_dir[TPG_PB_IRQ_LO +: TPG_CTRL_IRQ_EN_W]);
    st_nxt.rx = c_rd[TPG_PC_RX_PIN];
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{rdata: TPG_RST_DATA, ctrl: TPG_RST_CTRL, rx: 1'b0, irq: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign serial_receive_in = st_r.rx;
  assign ext_irq_req = st_r.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_pc_upper_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    $past(reg_rd) && ($past(reg_addr) == TPG_OFF_PC_DATA ||
      $past(reg_addr) == TPG_OFF_PC_DIR) |-> reg_rdata[7:3] == 5'h00)
    else $error("port c upper bits");
  chk_read_input_pin: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == TPG_OFF_PB_DATA && b_dir == '0 && !reg_wr
    |=> reg_rdata == $past(pb_i)) else $error("input read");
  chk_read_latch_out: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == TPG_OFF_PB_DATA && b_dir == 8'hFF
    |=> reg_rdata == $past(b_data)) else $error("latch read");
  chk_pa_od_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == TPG_OFF_PA_DATA |=>
      (reg_rdata & TPG_PA_OD_MASK) == ($past(pa_i) & TPG_PA_OD_MASK))
    else $error("open drain read");
  chk_usb_pin: assert property (@(posedge sys_clk) disable iff (!resetn)
    usb_sel && !small_pkg && $stable(st_r.ctrl) |=>
      pc_oe[TPG_PC_USB_PIN] && pc_o[TPG_PC_USB_PIN] == $past(usb_tx_active))
    else $error("usb indicator");
  chk_serial_tx: assert property (@(posedge sys_clk) disable iff (!resetn)
    ser_en && $stable(st_r.ctrl) |=>
      pc_oe[TPG_PC_TX_PIN] && pc_o[TPG_PC_TX_PIN] == $past(serial_tx))
    else $error("serial tx");
  chk_irq_or: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pb_i[7:4] & irq_en & ~b_dir[7:4]) != 4'h0 |=> ext_irq_req)
    else $error("irq or");
  chk_irq_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_en == 4'h0 |=> !ext_irq_req) else $error("irq without enable");
  chk_rd_one_cycle: assert property (@(posedge sys_clk) disable iff (!resetn)
    !reg_rd |=> reg_rdata == '0) else $error("read data stays");

  // usb indicator moved to port B pin 1 on the small package
  chk_usb_pb_pin: assert property (@(posedge sys_clk) disable iff (!resetn)
    usb_sel && small_pkg && $stable(st_r.ctrl) |=>
      pb_oe[TPG_PB_USB_PIN] && pb_o[TPG_PB_USB_PIN] == $past(usb_tx_active))
    else $error("usb indicator port b");

  // reserved slot always reads as zero
  chk_rsvd_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == TPG_OFF_RSVD7 |=> reg_rdata == TPG_RD_RSVD)
    else $error("reserved read");

  // direction register reads back as written
  chk_dir_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_rd && reg_addr == TPG_OFF_PA_DIR |=> reg_rdata == $past(a_dir))
    else $error("direction read");

  // open-drain pins of port A never carry a high drive value
  chk_pa_od_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pa_o & TPG_PA_OD_MASK) == '0) else $error("port a od drive");

  // receive input follows port C pin 0 while it is an input
  chk_rx_follow: assert property (@(posedge sys_clk) disable iff (!resetn)
    !c_dir[TPG_PC_RX_PIN] |=>
      serial_receive_in == $past(pc_i[TPG_PC_RX_PIN]))
    else $error("serial receive");

  // irq pins in output mode raise nothing
  chk_irq_out_mode: assert property (@(posedge sys_clk) disable iff (!resetn)
    b_dir[TPG_PB_IRQ_LO +: TPG_CTRL_IRQ_EN_W] == '1 |=> !ext_irq_req)
    else $error("irq from output pin");

  // unused control bit stays clear
  chk_ctrl_gap: assert property (@(posedge sys_clk) disable iff (!resetn)
    st_r.ctrl[TPG_CTRL_IRQ_EN_LO-1] == 1'b0) else $error("control gap bit");
endmodule

// [rtl/tpg_port.sv]
`timescale 1ns/1ps
// one port: data latch, direction, pin drive and read-back
module tpg_port #(
  parameter int W = 8,
  parameter logic [W-1:0] OD_MASK = '0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register access
  input wire logic wr_data,
  input wire logic wr_dir,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] data_q,
  output logic [W-1:0] dir_q,
  output logic [W-1:0] rd_val,
  // peripheral override
  input wire logic [W-1:0] alt_en,
  input wire logic [W-1:0] alt_val,
  // pins
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe
);
  import tpg_pkg::*;

  initial begin
    if (W < 1 || W > TPG_DW) $error("tpg_port width out of range");
  end

  typedef struct packed {
    logic [W-1:0] data;
    logic [W-1:0] dir;
    logic [W-1:0] po;
    logic [W-1:0] oe;
  } tpg_port_st_t;

  tpg_port_st_t st_r, st_nxt;
  logic [W-1:0] eff_dir, eff_val;

  always_comb begin
    st_nxt = st_r;
    if (wr_data) begin
      st_nxt.data = wdata;
    end
    if (wr_dir) begin
      st_nxt.dir = wdata;
    end
    eff_dir = (st_nxt.dir & ~alt_en) | alt_en;
    eff_val = (st_nxt.data & ~alt_en) | (alt_val & alt_en);
    // open drain: drive low only, never high
    st_nxt.po = eff_val & ~OD_MASK;
    st_nxt.oe = eff_dir & ~(OD_MASK & eff_val);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{data: '0, dir: '0, po: '0, oe: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign data_q = st_r.data;
  assign dir_q = st_r.dir;
  assign pin_o = st_r.po;
  assign pin_oe = st_r.oe;
  // latch for push-pull outputs, pin level otherwise
  assign rd_val = (st_r.dir & ~OD_MASK & st_r.data)
    | (~(st_r.dir & ~OD_MASK) & pin_i);

  chk_dir_reset_in: assert property (@(posedge sys_clk)
    $rose(resetn) |-> st_r.dir == '0) else $error("dir not cleared");
  chk_data_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_data |=> st_r.data == $past(wdata)) else $error("data lost");
  chk_dir_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_dir |=> st_r.dir == $past(wdata)) else $error("dir lost");
  chk_od_no_high: assert property (@(posedge sys_clk) disable iff (!resetn)
    ((pin_oe & OD_MASK) == '0 || (pin_o & pin_oe & OD_MASK) == '0))
    else $error("open drain high");
  chk_input_no_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!wr_dir && alt_en == '0 && $stable(alt_en)) |=>
      (pin_oe & ~st_r.dir) == '0) else $error("input driven");
endmodule

// [tb/tpg_bank_bench.sv]
`timescale 1ns/1ps
module tpg_bank_bench;
  import tpg_pkg::*;
  typedef struct {string nm; logic [7:0] v;} tpg_note_t;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_seen = 1'b0;
  logic usb_tx_active = 1'b0;
  logic serial_tx = 1'b0;
  logic [7:0] reg_rdata, pa_o, pa_oe, pb_o, pb_oe, pa_lvl, pb_lvl;
  logic [2:0] pc_o, pc_oe, pc_lvl;
  logic serial_receive_in, ext_irq_req;
  logic [7:0] lat [3];
  logic [7:0] dir [3];
  logic [7:0] ext [3] = '{default: 8'h00};
  tpg_note_t q [$];
  int n_errors = 0;
  int total_checks = 0;
  tpg_bank dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pa_i(pa_lvl), .pa_o(pa_o), .pa_oe(pa_oe),
    .pb_i(pb_lvl), .pb_o(pb_o), .pb_oe(pb_oe), .pc_i(pc_lvl), .pc_o(pc_o),
    .pc_oe(pc_oe), .usb_tx_active(usb_tx_active), .serial_tx(serial_tx),
    .serial_receive_in(serial_receive_in), .ext_irq_req(ext_irq_req));
  tpg_board board (.pa_o(pa_o), .pa_oe(pa_oe), .pb_o(pb_o), .pb_oe(pb_oe),
    .pc_o(pc_o), .pc_oe(pc_oe), .pa_ext(ext[0]), .pb_ext(ext[1]),
    .pc_ext(ext[2][2:0]), .pa_lvl(pa_lvl), .pb_lvl(pb_lvl), .pc_lvl(pc_lvl));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] mk(int p);
    return (p == 2) ? 8'h07 : 8'hFF;
  endfunction
  function automatic logic [7:0] od(int p);
    return (p == 0) ? TPG_PA_OD_MASK : 8'h00;
  endfunction
  // open-drain output bits read the pin, pulled low by a zero latch
  function automatic logic [7:0] exp_rd(int p);
    logic [7:0] pp;
    pp = dir[p] & ~od(p);
    return (pp & lat[p]) | (~pp & ext[p] & ~(dir[p] & od(p) & ~lat[p]));
  endfunction
  task automatic cmp(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic acc(logic [2:0] a, logic [7:0] d, logic w);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= ~w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e, string nm);
    q.push_back('{nm, e});
    acc(a, 8'h00, 1'b0);
  endtask
  task automatic pins(int p);
    logic [7:0] go, goe, eoe;
    tick(2);
    go = (p == 0) ? pa_o : (p == 1) ? pb_o : {5'h00, pc_o};
    goe = (p == 0) ? pa_oe : (p == 1) ? pb_oe : {5'h00, pc_oe};
    eoe = dir[p] & ~(od(p) & lat[p]);
    cmp("pin_oe", eoe, goe);
    cmp("pin_o", lat[p] & ~od(p), go);
  endtask
  // read data stands in the cycle after the strobe
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    tpg_note_t n;
    if (rd_seen && q.size() > 0) begin
      n = q.pop_front();
      cmp(n.nm, n.v, reg_rdata);
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    int p;
    logic [7:0] w;
    lat = '{default: 8'h00};
    dir = '{default: 8'h00};
    void'($urandom(32'hE3D6));
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00, "reset");
    $display("test reset done");
    repeat (24) begin
      p = $urandom_range(2);
      w = 8'($urandom);
      @(posedge sys_clk);
      ext[p] <= w & mk(p);
      w = 8'($urandom);
      dir[p] = w & mk(p);
      acc(3'(2 * p + 1), w, 1'b1);
      w = 8'($urandom);
      lat[p] = w & mk(p);
      acc(3'(2 * p), w, 1'b1);
      pins(p);
      rd(3'(2 * p), exp_rd(p), "data");
      rd(3'(2 * p + 1), dir[p], "dir");
    end
    $display("test ports done");
    w = 8'($urandom);
    acc(TPG_OFF_PB_DIR, 8'h00, 1'b1);
    acc(TPG_OFF_PB_DATA, w, 1'b1);
    rd(TPG_OFF_PB_DATA, ext[1], "pb_in");
    acc(TPG_OFF_PB_DIR, 8'hFF, 1'b1);
    rd(TPG_OFF_PB_DATA, w, "pb_latch");
    rd(TPG_OFF_PB_DIR, 8'hFF, "pb_dir");
    $display("test latch done");
    acc(TPG_OFF_RSVD7, 8'hFF, 1'b1);
    rd(TPG_OFF_RSVD7, 8'h00, "reserved");
    acc(TPG_OFF_CTRL, 8'hFF, 1'b1);
    rd(TPG_OFF_CTRL, 8'hF7, "control");
    acc(TPG_OFF_PB_DIR, 8'h00, 1'b1);
    for (int k = 0; k < 4; k++) begin
      w = 8'h10 << k;
      acc(TPG_OFF_CTRL, w, 1'b1);
      ext[1] <= w;
      tick(3);
      cmp("irq_own", 8'h01, {7'h00, ext_irq_req});
      @(posedge sys_clk);
      ext[1] <= 8'hF0 & ~w;
      tick(3);
      cmp("irq_other", 8'h00, {7'h00, ext_irq_req});
    end
    acc(TPG_OFF_CTRL, 8'hF0, 1'b1);
    tick(3);
    cmp("irq_or", 8'h01, {7'h00, ext_irq_req});
    $display("test irq done");
    acc(TPG_OFF_CTRL, 8'h03, 1'b1);
    usb_tx_active <= 1'b1;
    serial_tx <= 1'b1;
    tick(3);
    cmp("pc_alt", 8'h0F, {4'h0, pc_oe[2:1], pc_o[2:1]});
    @(posedge sys_clk);
    usb_tx_active <= 1'b0;
    serial_tx <= 1'b0;
    tick(3);
    cmp("pc_idle", 8'h0C, {4'h0, pc_oe[2:1], pc_o[2:1]});
    acc(TPG_OFF_CTRL, 8'h05, 1'b1);
    usb_tx_active <= 1'b1;
    tick(3);
    cmp("pb_usb", 8'h03, {6'h00, pb_oe[1], pb_o[1]});
    acc(TPG_OFF_PC_DIR, 8'h00, 1'b1);
    for (int v = 1; v >= 0; v--) begin
      @(posedge sys_clk);
      ext[2] <= 8'(v);
      tick(3);
      cmp("serial_rx", 8'(v), {7'h00, serial_receive_in});
    end
    $display("test override done");
    end_of_test();
  end
endmodule

// [tb/tpg_board.sv]
`timescale 1ns/1ps
// board side of the pins
module tpg_board (
  // bank drive
  input wire logic [7:0] pa_o,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pb_o,
  input wire logic [7:0] pb_oe,
  input wire logic [2:0] pc_o,
  input wire logic [2:0] pc_oe,
  // board drive
  input wire logic [7:0] pa_ext,
  input wire logic [7:0] pb_ext,
  input wire logic [2:0] pc_ext,
  // resolved levels
  output logic [7:0] pa_lvl,
  output logic [7:0] pb_lvl,
  output logic [2:0] pc_lvl
);
  // bank wins where it drives, board elsewhere
  assign pa_lvl = (pa_oe & pa_o) | (~pa_oe & pa_ext);
  assign pb_lvl = (pb_oe & pb_o) | (~pb_oe & pb_ext);
  assign pc_lvl = (pc_oe & pc_o) | (~pc_oe & pc_ext);
endmodule
